// file: src/cct_defs.vh
`ifndef CCT_DEFS_VH
`define CCT_DEFS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define CCT_IDX_CLK_EN    16'hFF16
`define CCT_IDX_RUN_CTL   16'hFF40
`define CCT_IDX_DATA_LO   16'hFF41
`define CCT_IDX_DATA_HI   16'hFF42
`define CCT_IDX_MASK_FAST 16'hFFEE
`define CCT_IDX_MASK_SLOW 16'hFFEF
`define CCT_IDX_FLAG_FAST 16'hFFFE
`define CCT_IDX_FLAG_SLOW 16'hFFFF
`define CCT_IDX_IRQ_STAT  16'h0100
`define CCT_IDX_IRQ_CLR   16'h0101
`define CCT_IDX_IRQ_EN    16'h0102

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CCT_BIT_GATE  0
`define CCT_BIT_RUN   0
`define CCT_BIT_CLEAR 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CCT_RST_GATE  1'b0
`define CCT_RST_RUN   1'b0
`define CCT_RST_COUNT 8'h00
`define CCT_RST_MASK  8'h00
`define CCT_RST_FLAG  8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CCT_CRYSTAL_HZ 32768
`define CCT_PRESCALE   128
`define CCT_COUNT_HZ   256

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define CCT_RESP_OKAY   2'h0
`define CCT_RESP_SLVERR 2'h2

`endif

// file: src/cct_edge_sync.v
`timescale 1ns/1ps

module cct_edge_sync (
    input wire aclk,
    input wire aresetn,
    input wire async_in,
    output reg rise_q
);

    // ------------------------------------------------------------
    // Two-flop synchroniser, then rising-edge detect
    // ------------------------------------------------------------
    reg meta_q;
    reg sync_q;
    reg prev_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
            rise_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
            rise_q <= sync_q & ~prev_q;
        end
    end

endmodule // cct_edge_sync

// file: src/cct_timer.v
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "cct_defs.vh"

module cct_timer #(
    parameter ADDR_W = 18,
    parameter PRESCALE = `CCT_PRESCALE
) (
    input wire aclk,
    input wire aresetn,
    input wire crystal_oscillator,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg irq_q
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function [15:0] reg_index;
        input [ADDR_W-1:0] addr;
        begin
            reg_index = addr[17:2];
        end
    endfunction

    function known_index;
        input [15:0] idx;
        begin
            case (idx)
                `CCT_IDX_CLK_EN, `CCT_IDX_RUN_CTL, `CCT_IDX_DATA_LO,
                `CCT_IDX_DATA_HI, `CCT_IDX_MASK_FAST, `CCT_IDX_MASK_SLOW,
                `CCT_IDX_FLAG_FAST, `CCT_IDX_FLAG_SLOW, `CCT_IDX_IRQ_STAT,
                `CCT_IDX_IRQ_CLR, `CCT_IDX_IRQ_EN: known_index = 1'b1;
                default: known_index = 1'b0;
            endcase
        end
    endfunction

    function [6:0] prescale_last;
        input [31:0] ratio;
        reg [31:0] last;
        begin
            last = ratio - 32'h00000001;
            prescale_last = last[6:0];
        end
    endfunction

    function [7:0] tap_falls;
        input [7:0] old_bits;
        input [7:0] new_bits;
        begin
            tap_falls = old_bits & ~new_bits;
        end
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    reg timer_clock_gate_q;
    reg count_run_q;
    reg [7:0] count_bits_q;
    reg [7:0] count_bits_d;
    reg [3:0] hi_latch_q;
    reg [7:0] tick_irq_mask_q;
    reg [7:0] tick_irq_flag_q;
    reg [7:0] tick_irq_flag_d;
    reg [6:0] prescale_q;
    reg [6:0] prescale_d;
    reg tick_256_q;
    reg [7:0] tap_fall_q;

    reg aw_full_q;
    reg [15:0] aw_idx_q;
    reg w_full_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    wire crystal_rise;
    wire aw_take;
    wire w_take;
    wire wr_do;
    wire wr_lane0;
    wire ar_take;
    wire [15:0] ar_idx;
    wire count_step;
    wire count_clear;
    wire prescale_wrap;
    wire lo_read;
    reg [7:0] flag_clr;
    reg [31:0] rd_value;

    // ------------------------------------------------------------
    // Crystal clock synchroniser
    // ------------------------------------------------------------
    cct_edge_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(crystal_oscillator),
        .rise_q(crystal_rise)
    );

    // ------------------------------------------------------------
    // Prescaler: one tick per PRESCALE crystal periods (128 by default)
    // ------------------------------------------------------------
    assign prescale_wrap = crystal_rise &&
        (prescale_q == prescale_last(PRESCALE));

    always @* begin
        prescale_d = prescale_q;
        if (prescale_wrap) begin
            prescale_d = 7'h00;
        end else if (crystal_rise) begin
            prescale_d = prescale_q + 7'h01;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            prescale_q <= 7'h00;
            tick_256_q <= 1'b0;
        end else begin
            prescale_q <= prescale_d;
            tick_256_q <= prescale_wrap;
        end
    end

    // ------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign wr_do = aw_full_q & w_full_q & ~s_axi_bvalid;
    assign wr_lane0 = wr_do & w_strb_q[0];
    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign ar_idx = reg_index(s_axi_araddr);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CCT_RESP_OKAY;
            aw_full_q <= 1'b0;
            aw_idx_q <= 16'h0000;
            w_full_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_full_q <= 1'b1;
                aw_idx_q <= reg_index(s_axi_awaddr);
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= known_index(aw_idx_q) ? `CCT_RESP_OKAY :
                    `CCT_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    assign count_clear = wr_lane0 && (aw_idx_q == `CCT_IDX_RUN_CTL) &&
        w_data_q[`CCT_BIT_CLEAR];

    always @(posedge aclk) begin
        if (!aresetn) begin
            timer_clock_gate_q <= `CCT_RST_GATE;
            count_run_q <= `CCT_RST_RUN;
            tick_irq_mask_q <= `CCT_RST_MASK;
        end else if (wr_lane0) begin
            case (aw_idx_q)
                `CCT_IDX_CLK_EN: begin
                    timer_clock_gate_q <= w_data_q[`CCT_BIT_GATE];
                end
                `CCT_IDX_RUN_CTL: begin
                    count_run_q <= w_data_q[`CCT_BIT_RUN];
                end
                `CCT_IDX_MASK_FAST: begin
                    tick_irq_mask_q[3:0] <= w_data_q[3:0];
                end
                `CCT_IDX_MASK_SLOW: begin
                    tick_irq_mask_q[7:4] <= w_data_q[3:0];
                end
                `CCT_IDX_IRQ_EN: begin
                    tick_irq_mask_q <= w_data_q[7:0];
                end
                default: begin
                    timer_clock_gate_q <= timer_clock_gate_q;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    assign count_step = tick_256_q & timer_clock_gate_q & count_run_q;

    always @* begin
        count_bits_d = count_bits_q;
        if (count_clear) begin
            count_bits_d = `CCT_RST_COUNT;
        end else if (count_step) begin
            count_bits_d = count_bits_q + 8'h01;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            count_bits_q <= `CCT_RST_COUNT;
            tap_fall_q <= 8'h00;
        end else begin
            count_bits_q <= count_bits_d;
            tap_fall_q <= (count_clear || !count_step) ? 8'h00 :
                tap_falls(count_bits_q, count_bits_d);
        end
    end

    // ------------------------------------------------------------
    // High nibble latch
    // ------------------------------------------------------------
    assign lo_read = ar_take && (ar_idx == `CCT_IDX_DATA_LO);

    always @(posedge aclk) begin
        if (!aresetn) begin
            hi_latch_q <= 4'h0;
        end else if (lo_read) begin
            hi_latch_q <= count_bits_q[7:4];
        end
    end

    // ------------------------------------------------------------
    // Interrupt flags
    // ------------------------------------------------------------
    always @* begin
        flag_clr = 8'h00;
        if (wr_lane0) begin
            case (aw_idx_q)
                `CCT_IDX_FLAG_FAST: flag_clr = {4'h0, w_data_q[3:0]};
                `CCT_IDX_FLAG_SLOW: flag_clr = {w_data_q[3:0], 4'h0};
                `CCT_IDX_IRQ_CLR: flag_clr = w_data_q[7:0];
                default: flag_clr = 8'h00;
            endcase
        end
        tick_irq_flag_d = (tick_irq_flag_q & ~flag_clr) | tap_fall_q;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            tick_irq_flag_q <= `CCT_RST_FLAG;
            irq_q <= 1'b0;
        end else begin
            tick_irq_flag_q <= tick_irq_flag_d;
            irq_q <= |(tick_irq_flag_d & tick_irq_mask_q);
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always @* begin
        rd_value = 32'h00000000;
        case (ar_idx)
            `CCT_IDX_CLK_EN: rd_value[`CCT_BIT_GATE] = timer_clock_gate_q;
            `CCT_IDX_RUN_CTL: rd_value[`CCT_BIT_RUN] = count_run_q;
            `CCT_IDX_DATA_LO: rd_value[3:0] = count_bits_q[3:0];
            `CCT_IDX_DATA_HI: rd_value[3:0] = hi_latch_q;
            `CCT_IDX_MASK_FAST: rd_value[3:0] = tick_irq_mask_q[3:0];
            `CCT_IDX_MASK_SLOW: rd_value[3:0] = tick_irq_mask_q[7:4];
            `CCT_IDX_FLAG_FAST: rd_value[3:0] = tick_irq_flag_q[3:0];
            `CCT_IDX_FLAG_SLOW: rd_value[3:0] = tick_irq_flag_q[7:4];
            `CCT_IDX_IRQ_STAT: rd_value[7:0] = tick_irq_flag_q;
            `CCT_IDX_IRQ_EN: rd_value[7:0] = tick_irq_mask_q;
            default: rd_value = 32'h00000000;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CCT_RESP_OKAY;
        end else begin
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_value;
                s_axi_rresp <= known_index(ar_idx) ? `CCT_RESP_OKAY :
                    `CCT_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // cct_timer

// file: bench/cct_xtal.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Crystal source
// ----------------------------------------------------------------
// Free running, phase unrelated to aclk, 16 aclk cycles a period
module cct_xtal (
    output reg xtal
);
    initial begin
        xtal = 1'b0;
        #1.3;
        forever #40 xtal = ~xtal;
    end
endmodule // cct_xtal

// file: bench/cct_timer_chk.sv
`timescale 1ns/1ps
`include "cct_defs.vh"

module cct_timer_chk #(
    parameter ADDR_W = 18
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire irq_q
);
    // ------------------------------------------------------------
    // Index of the read under way
    // ------------------------------------------------------------
    reg [ADDR_W-3:0] ridx_q;
    always @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            ridx_q <= s_axi_araddr[ADDR_W-1:2];
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_b_after_w: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_r_after_ar: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    a_w_blocked: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_clear_reads0: assert property (s_axi_rvalid &&
        ridx_q == `CCT_IDX_RUN_CTL |-> s_axi_rdata[31:1] == 31'h0)
        else $error("clear bit read back nonzero");
    a_nibble_only: assert property (s_axi_rvalid &&
        (ridx_q == `CCT_IDX_DATA_LO || ridx_q == `CCT_IDX_DATA_HI)
        |-> s_axi_rdata[31:4] == 28'h0) else $error("data wider than nibble");
    a_unmapped_err: assert property (s_axi_rvalid && ridx_q < 16'h0100
        |-> s_axi_rresp == `CCT_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_irq_held: assert property ($fell(irq_q) |-> s_axi_bvalid ||
        $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("interrupt dropped without a write");
endmodule // cct_timer_chk

bind cct_timer cct_timer_chk #(.ADDR_W(ADDR_W)) chk_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .irq_q(irq_q));

// file: bench/cct_timer_tb.sv
`timescale 1ns/1ps
`include "cct_defs.vh"

module cct_timer_tb;
    localparam [15:0] CE = `CCT_IDX_CLK_EN;
    localparam [15:0] RC = `CCT_IDX_RUN_CTL;
    localparam [15:0] LO = `CCT_IDX_DATA_LO;
    localparam [15:0] HI = `CCT_IDX_DATA_HI;
    localparam [15:0] MF = `CCT_IDX_MASK_FAST;
    localparam [15:0] MS = `CCT_IDX_MASK_SLOW;
    localparam [15:0] FF = `CCT_IDX_FLAG_FAST;
    localparam [15:0] FS = `CCT_IDX_FLAG_SLOW;
    localparam [15:0] ST = `CCT_IDX_IRQ_STAT;
    localparam [15:0] CL = `CCT_IDX_IRQ_CLR;
    localparam [15:0] EN = `CCT_IDX_IRQ_EN;
    reg aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    reg [17:0] awaddr, araddr;
    reg [31:0] wdata, v;
    wire xtal, awready, wready, bvalid, arready, rvalid, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    integer errors, num_checks, i;
    cct_xtal xt_u (.xtal(xtal));
    cct_timer #(.PRESCALE(4)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .crystal_oscillator(xtal), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq_q(irq));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // ------------------------------------------------------------
    // Result, check and bus tasks
    // ------------------------------------------------------------
    task wrap_up;
        begin
            if (errors == 0 && num_checks > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("[ERR] %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task hang;
        begin
            errors = errors + 1;
            wrap_up;
        end
    endtask
    task wr(input [15:0] ix, input [31:0] d, input [1:0] er);
        integer n;
        begin
            @(posedge aclk);
            awaddr <= {ix, 2'b00};
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            for (n = 0; n < 50 && bvalid !== 1'b1; n = n + 1) begin
                @(posedge aclk);
                if (awready === 1'b1) awvalid <= 1'b0;
                if (wready === 1'b1) wvalid <= 1'b0;
            end
            if (n >= 50) hang;
            chk($sformatf("bresp %h", ix), er, bresp);
            bready <= 1'b0;
        end
    endtask
    task rd(input [15:0] ix, input [1:0] er);
        integer n;
        begin
            @(posedge aclk);
            araddr <= {ix, 2'b00};
            arvalid <= 1'b1;
            rready <= 1'b1;
            for (n = 0; n < 50 && rvalid !== 1'b1; n = n + 1) begin
                @(posedge aclk);
                if (arready === 1'b1) arvalid <= 1'b0;
            end
            if (n >= 50) hang;
            v = rdata;
            chk($sformatf("rresp %h", ix), er, rresp);
            rready <= 1'b0;
        end
    endtask
    task rc(input [15:0] ix, input [31:0] e);
        begin
            rd(ix, `CCT_RESP_OKAY);
            chk($sformatf("reg %h", ix), e, v);
        end
    endtask
    task w(input [15:0] ix, input [31:0] d);
        wr(ix, d, `CCT_RESP_OKAY);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        begin
            rc(CE, 0);
            rc(RC, 0);
            rc(LO, 0);
            rc(HI, 0);
            rc(MF, 0);
            rc(MS, 0);
            rc(FF, 0);
            rc(FS, 0);
            rc(ST, 0);
            rc(EN, 0);
        end
    endtask
    task t_bus;
        begin
            wr(16'h0010, 32'h5, `CCT_RESP_SLVERR);
            rd(16'h0010, `CCT_RESP_SLVERR);
            w(LO, 32'hF);
            rc(LO, 0);
            w(MF, 32'hF);
            w(MS, 32'h5);
            rc(MF, 32'hF);
            rc(MS, 32'h5);
            rc(EN, 32'h5F);
            w(EN, 32'hA0);
            rc(MF, 0);
            rc(MS, 32'hA);
            w(EN, 0);
        end
    endtask
    task t_wrap;
        begin
            w(CE, 1);
            w(RC, 1);
            repeat (1500) @(posedge aclk);
            chk("irq masked", 0, irq);
            rc(FF, 32'hF);
            w(MS, 32'h8);
            for (i = 0; i < 20000 && irq !== 1'b1; i = i + 1) @(posedge aclk);
            if (i >= 20000) hang;
            chk("irq on wrap", 1, irq);
            w(RC, 0);
            rd(LO, `CCT_RESP_OKAY);
            rc(HI, 0);
            rc(FS, 32'hF);
            rc(ST, 32'hFF);
            w(FS, 32'h5);
            rc(FS, 32'hA);
            chk("irq held", 1, irq);
            w(CL, 32'h80);
            rc(FS, 32'h2);
            chk("irq cleared", 0, irq);
        end
    endtask
    task t_latch;
        begin
            rd(LO, `CCT_RESP_OKAY);
            w(RC, 1);
            repeat (1100) @(posedge aclk);
            w(RC, 0);
            rc(HI, 0);
            rd(LO, `CCT_RESP_OKAY);
            rc(HI, 1);
            rd(LO, `CCT_RESP_OKAY);
            repeat (300) @(posedge aclk);
            rc(LO, v);
        end
    endtask
    task t_clear;
        begin
            w(RC, 32'h2);
            rc(LO, 0);
            rc(HI, 0);
            rc(RC, 0);
            w(CE, 0);
            w(RC, 1);
            rc(RC, 1);
            repeat (300) @(posedge aclk);
            rc(LO, 0);
            w(CE, 1);
            repeat (300) @(posedge aclk);
            w(RC, 0);
            rd(LO, `CCT_RESP_OKAY);
            chk("count rate", 1, v == 32'h4 || v == 32'h5);
        end
    endtask
    initial begin
        errors = 0;
        num_checks = 0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 18'h0;
        araddr = 18'h0;
        wdata = 32'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_bus;
        t_wrap;
        t_latch;
        t_clear;
        wrap_up;
    end
endmodule // cct_timer_tb
